// [rtl/fcs_pkg.sv]
// ****************************************************************
// flash command sequencer constants and types
// ****************************************************************
package fcs_pkg;

  // array geometry
  localparam int          FLASH_BYTES  = 16384;
  localparam int          SECTOR_BYTES = 4096;
  localparam logic [15:0] FLASH_BASE   = 16'hC000;
  localparam logic [15:0] FLASH_TOP    = 16'hFFFF;
  localparam int          IDX_W        = 14;
  localparam int          LOW_W        = 12;

  // unlock field codes
  localparam logic [3:0] UNLOCK_ON  = 4'h3;
  localparam logic [3:0] UNLOCK_OFF = 4'hC;

  // command cycle addresses (low 12 bits, security address full 16 bits) and data
  localparam logic [11:0] CA_555   = 12'h555;
  localparam logic [11:0] CA_AAA   = 12'hAAA;
  localparam logic [15:0] SEC_ADDR = 16'hFF7F;
  localparam logic [7:0]  D_AA     = 8'hAA;
  localparam logic [7:0]  D_55     = 8'h55;
  localparam logic [7:0]  D_PROG   = 8'hA0;
  localparam logic [7:0]  D_ERASE  = 8'h80;
  localparam logic [7:0]  D_SECT   = 8'h30;
  localparam logic [7:0]  D_CHIP   = 8'h10;
  localparam logic [7:0]  D_IDIN   = 8'h90;
  localparam logic [7:0]  D_IDOUT  = 8'hF0;
  localparam logic [7:0]  D_SECP   = 8'hA5;
  localparam logic [7:0]  D_SECV   = 8'h00;
  localparam logic [7:0]  D_ERASED = 8'hFF;

  // product id map
  localparam logic [15:0] ID_VEND_ADDR = 16'hF000;
  localparam logic [15:0] ID_MAC_ADDR  = 16'hF001;
  localparam logic [15:0] ID_SIZE_ADDR = 16'hF002;
  localparam logic [7:0]  ID_SIZE_16K  = 8'h03;
  localparam logic [7:0]  SEC_ON_VAL   = 8'h00;
  localparam int          TOG_BIT      = 6;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS  = 40000;
  localparam int ERASE_TIME_MS = 30;
  localparam int PROG_CYC      = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYC     = ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W         = 19;

  // cpu bus cycle toward flash
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } fcs_bus_s;

  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_U1   = 4'h1,
    S_U2   = 4'h2,
    S_PROG = 4'h3,
    S_E1   = 4'h4,
    S_E2   = 4'h5,
    S_E3   = 4'h6,
    S_SEC  = 4'h7,
    S_BUSY = 4'h8
  } fcs_state_e;

endpackage

// [rtl/fcs_top.sv]
// Overview of operation
// - 16384-byte array sits at C000H..FFFFH.
// - sequences run only while unlock field equals 0011B.
// - writing 1100B to unlock field disables sequence execution.
// - unlock field resets to 1100B.
// - any flash read or write clears the standby request bit.
// - an interrupt clears the standby request bit before vector fetch.
// - low-power entry clears standby bit; current cut in those modes.
// - standby only takes effect when set from code in RAM.
// - unlock cycles compare low 12 address bits only.
// - security program: AA, 55, A5, then 00H at FF7FH.
// - byte program: AA, 55, A0, then target address and byte.
// - byte program finishes within 40 us.
// - no new sequence is taken while an operation is busy.
// - while busy, each read returns bit 6 inverted from the last.
// - sector erase: six writes ending sector address with 30H.
// - upper 4 address bits of sixth write select the sector.
// - sector erase finishes within 30 ms with bit 6 toggling.
// - sector erase refused in parallel programmer mode.
// - chip erase ends 555H/10H; whole array then reads FFH.
// - security program finishes within 40 us, toggle-polled.
// - product id entry 90H; exit by F0H or three-cycle F0H.
// - first toggle-bit read after a start returns 1.
`timescale 1ns/1ps

module fcs_top #(
  parameter int          ERASE_CYCLES = fcs_pkg::ERASE_CYC,
  parameter logic [7:0]  VENDOR_ID    = 8'h5A, // arbitrary value
  parameter logic [7:0]  MACRO_ID     = 8'h3C  // arbitrary value
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire fcs_pkg::fcs_bus_s bus,
  input  wire logic              unlock_wr,
  input  wire logic [3:0]        unlock_wdata,
  input  wire logic              standby_wr,
  input  wire logic              standby_wdata,
  input  wire logic              exec_in_ram,
  input  wire logic              irq_taken,
  input  wire logic              low_power_entry,
  input  wire logic              low_power_mode,
  input  wire logic              parallel_mode,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic                   busy,
  output logic                   id_mode,
  output logic [3:0]             command_unlock_field,
  output logic                   standby_request_bit,
  output logic                   flash_current_cut
);

  // ****************************************************************
  // storage and state
  // ****************************************************************
  logic [7:0]                  mem [0:fcs_pkg::FLASH_BYTES-1];
  fcs_pkg::fcs_state_e         state;
  fcs_pkg::fcs_state_e         next_state;
  logic [fcs_pkg::CNT_W-1:0]   cnt;
  logic [fcs_pkg::IDX_W-1:0]   wipe_ptr;
  logic [fcs_pkg::IDX_W-1:0]   wipe_last;
  logic                        wiping;
  logic                        tog;
  logic                        secured;
  logic                        stby_from_ram;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire                       in_flash  = bus.addr >= fcs_pkg::FLASH_BASE;
  wire [fcs_pkg::IDX_W-1:0]  idx       = bus.addr[fcs_pkg::IDX_W-1:0];
  wire [fcs_pkg::LOW_W-1:0]  low       = bus.addr[fcs_pkg::LOW_W-1:0];
  wire                       at_555    = low == fcs_pkg::CA_555;
  wire                       at_aaa    = low == fcs_pkg::CA_AAA;
  wire                       enabled   =
    command_unlock_field == fcs_pkg::UNLOCK_ON;
  wire                       fl_wr     = bus.wr && in_flash;
  wire                       fl_rd     = bus.rd && in_flash;
  wire                       seq_wr    = fl_wr && enabled;
  wire [7:0]                 d         = bus.wdata;
  wire                       cnt_done  = cnt == '0;
  wire                       op_end    = state == fcs_pkg::S_BUSY
                                         && cnt_done && !wiping;

  // ****************************************************************
  // command decode
  // ****************************************************************
  logic                      start_prog;
  logic                      start_sect;
  logic                      start_chip;
  logic                      start_sec;
  logic                      id_enter;
  logic                      id_leave;

  // next-state decode of the unlock sequences
  always_comb begin
    next_state = state;
    start_prog = 1'b0;
    start_sect = 1'b0;
    start_chip = 1'b0;
    start_sec  = 1'b0;
    id_enter   = 1'b0;
    id_leave   = 1'b0;
    unique case (state)
      fcs_pkg::S_IDLE: begin
        if (seq_wr && at_555 && d == fcs_pkg::D_AA) begin
          next_state = fcs_pkg::S_U1;
        end else if (seq_wr && d == fcs_pkg::D_IDOUT) begin
          id_leave = 1'b1;
        end
      end
      fcs_pkg::S_U1: begin
        if (seq_wr) begin
          next_state = (at_aaa && d == fcs_pkg::D_55) ?
                       fcs_pkg::S_U2 : fcs_pkg::S_IDLE;
        end
      end
      fcs_pkg::S_U2: begin
        if (seq_wr) begin
          next_state = fcs_pkg::S_IDLE;
          if (at_555) begin
            unique case (d)
              fcs_pkg::D_PROG:  next_state = fcs_pkg::S_PROG;
              fcs_pkg::D_ERASE: next_state = fcs_pkg::S_E1;
              fcs_pkg::D_SECP:  next_state = fcs_pkg::S_SEC;
              fcs_pkg::D_IDIN:  id_enter   = 1'b1;
              fcs_pkg::D_IDOUT: id_leave   = 1'b1;
              default:          next_state = fcs_pkg::S_IDLE;
            endcase
          end
        end
      end
      fcs_pkg::S_PROG: begin
        if (seq_wr) begin
          start_prog = 1'b1;
          next_state = fcs_pkg::S_BUSY;
        end
      end
      fcs_pkg::S_E1: begin
        if (seq_wr) begin
          next_state = (at_555 && d == fcs_pkg::D_AA) ?
                       fcs_pkg::S_E2 : fcs_pkg::S_IDLE;
        end
      end
      fcs_pkg::S_E2: begin
        if (seq_wr) begin
          next_state = (at_aaa && d == fcs_pkg::D_55) ?
                       fcs_pkg::S_E3 : fcs_pkg::S_IDLE;
        end
      end
      fcs_pkg::S_E3: begin
        if (seq_wr) begin
          next_state = fcs_pkg::S_IDLE;
          if (d == fcs_pkg::D_SECT && !parallel_mode) begin
            start_sect = 1'b1;
            next_state = fcs_pkg::S_BUSY;
          end else if (at_555 && d == fcs_pkg::D_CHIP) begin
            start_chip = 1'b1;
            next_state = fcs_pkg::S_BUSY;
          end
        end
      end
      fcs_pkg::S_SEC: begin
        if (seq_wr) begin
          if (bus.addr == fcs_pkg::SEC_ADDR && d == fcs_pkg::D_SECV) begin
            start_sec  = 1'b1;
            next_state = fcs_pkg::S_BUSY;
          end else begin
            next_state = fcs_pkg::S_IDLE;
          end
        end
      end
      fcs_pkg::S_BUSY: begin
        if (op_end) begin
          next_state = fcs_pkg::S_IDLE;
        end
      end
      default: next_state = fcs_pkg::S_IDLE;
    endcase
    // a disabled field drops any partial sequence
    if (!enabled && state != fcs_pkg::S_BUSY) begin
      next_state = fcs_pkg::S_IDLE;
    end
  end

  wire                       start_any = start_prog | start_sect
                                         | start_chip | start_sec;
  wire                       start_wipe = start_sect | start_chip;
  wire [fcs_pkg::CNT_W-1:0]  load_prog  =
    fcs_pkg::CNT_W'(fcs_pkg::PROG_CYC - 1);
  wire [fcs_pkg::CNT_W-1:0]  load_erase =
    fcs_pkg::CNT_W'(ERASE_CYCLES - 1);
  wire [fcs_pkg::IDX_W-1:0]  sect_base  =
    {bus.addr[fcs_pkg::IDX_W-1:fcs_pkg::LOW_W], {fcs_pkg::LOW_W{1'b0}}};
  wire [fcs_pkg::IDX_W-1:0]  sect_last  =
    {bus.addr[fcs_pkg::IDX_W-1:fcs_pkg::LOW_W], {fcs_pkg::LOW_W{1'b1}}};

  // ****************************************************************
  // sequencer and busy timer
  // ****************************************************************
  // state, busy count and erase walk
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= fcs_pkg::S_IDLE;
      cnt       <= '0;
      busy      <= 1'b0;
      wiping    <= 1'b0;
      wipe_ptr  <= '0;
      wipe_last <= '0;
    end else begin
      state <= next_state;
      busy  <= next_state == fcs_pkg::S_BUSY;
      if (start_any) begin
        cnt <= start_wipe ? load_erase : load_prog;
      end else if (!cnt_done) begin
        cnt <= cnt - 1'b1;
      end
      if (start_sect) begin
        wipe_ptr  <= sect_base;
        wipe_last <= sect_last;
        wiping    <= 1'b1;
      end else if (start_chip) begin
        wipe_ptr  <= '0;
        wipe_last <= '1;
        wiping    <= 1'b1;
      end else if (wiping) begin
        wipe_ptr <= wipe_ptr + 1'b1;
        wiping   <= wipe_ptr != wipe_last;
      end
    end
  end

  // array writes: byte program ands, erase walk writes erased value
  always_ff @(posedge clk) begin
    if (start_prog) begin
      mem[idx] <= mem[idx] & d;
    end else if (wiping) begin
      mem[wipe_ptr] <= fcs_pkg::D_ERASED;
    end
  end

  // security flag, id mode and toggle bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      secured <= 1'b0;
      id_mode <= 1'b0;
      tog     <= 1'b1;
    end else begin
      if (start_sec) begin
        secured <= 1'b1;
      end else if (start_chip) begin
        secured <= 1'b0;
      end
      if (id_enter) begin
        id_mode <= 1'b1;
      end else if (id_leave) begin
        id_mode <= 1'b0;
      end
      if (start_any) begin
        tog <= 1'b1;
      end else if (fl_rd && busy) begin
        tog <= ~tog;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [7:0] id_data;
  logic [7:0] next_rd;

  // product id map and busy toggle overlay
  always_comb begin
    unique case (bus.addr)
      fcs_pkg::ID_VEND_ADDR: id_data = VENDOR_ID;
      fcs_pkg::ID_MAC_ADDR:  id_data = MACRO_ID;
      fcs_pkg::ID_SIZE_ADDR: id_data = fcs_pkg::ID_SIZE_16K;
      fcs_pkg::SEC_ADDR:     id_data = secured ? fcs_pkg::SEC_ON_VAL
                                               : fcs_pkg::D_ERASED;
      default:               id_data = mem[idx];
    endcase
    next_rd = id_mode ? id_data : mem[idx];
    if (busy) begin
      next_rd[fcs_pkg::TOG_BIT] = tog;
    end
  end

  // registered read answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= fl_rd;
      if (fl_rd) begin
        rd_data <= next_rd;
      end
    end
  end

  // ****************************************************************
  // unlock field and standby control
  // ****************************************************************
  wire stby_clr = fl_rd | fl_wr | irq_taken | low_power_entry;

  // unlock field, standby bit and current cut
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      command_unlock_field <= fcs_pkg::UNLOCK_OFF;
      standby_request_bit  <= 1'b0;
      stby_from_ram        <= 1'b0;
      flash_current_cut    <= 1'b0;
    end else begin
      if (unlock_wr) begin
        command_unlock_field <= unlock_wdata;
      end
      if (standby_wr) begin
        standby_request_bit <= standby_wdata;
        stby_from_ram       <= standby_wdata && exec_in_ram;
      end else if (stby_clr) begin
        standby_request_bit <= 1'b0;
        stby_from_ram       <= 1'b0;
      end
      flash_current_cut <= low_power_mode
        || (stby_from_ram && !stby_clr && !standby_wr)
        || (standby_wr && standby_wdata && exec_in_ram);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_reset_lock;
    $rose(reset_n) |-> command_unlock_field == fcs_pkg::UNLOCK_OFF;
  endproperty
  a_reset_lock: assert property (p_reset_lock)
    else $error("unlock field not disabled after reset");

  property p_locked_no_start;
    !enabled |-> !start_any;
  endproperty
  a_locked_no_start: assert property (p_locked_no_start)
    else $error("operation started while locked");

  property p_clear_on_access;
    (fl_rd || fl_wr) && !standby_wr |=> !standby_request_bit;
  endproperty
  a_clear_on_access: assert property (p_clear_on_access)
    else $error("standby bit survived flash access");

  property p_clear_on_irq;
    (irq_taken || low_power_entry) && !standby_wr |=> !standby_request_bit;
  endproperty
  a_clear_on_irq: assert property (p_clear_on_irq)
    else $error("standby bit survived interrupt or low power");

  property p_flash_set_no_cut;
    standby_wr && !exec_in_ram && !low_power_mode |=> !flash_current_cut;
  endproperty
  a_flash_set_no_cut: assert property (p_flash_set_no_cut)
    else $error("standby from flash cut current");

  property p_first_tog_one;
    $rose(busy) ##1 (busy && fl_rd) |=> rd_data[fcs_pkg::TOG_BIT];
  endproperty
  a_first_tog_one: assert property (p_first_tog_one)
    else $error("first toggle read not one");

  property p_toggle;
    (busy && fl_rd) ##1 !fl_rd ##1 (busy && fl_rd)
      |=> rd_data[fcs_pkg::TOG_BIT] != $past(rd_data[fcs_pkg::TOG_BIT], 2);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle bit did not invert");

  property p_prog_time;
    start_prog |=> busy [*1] ##[1:400] !busy;
  endproperty
  a_prog_time: assert property (p_prog_time)
    else $error("byte program exceeded its time");

  property p_busy_hold;
    busy |-> state == fcs_pkg::S_BUSY && !id_enter && !start_any;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("command taken while busy");

  property p_abort;
    state == fcs_pkg::S_U1 && seq_wr && !(at_aaa && d == fcs_pkg::D_55)
      |=> state == fcs_pkg::S_IDLE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("bad unlock write did not abort");

  property p_parallel_no_sect;
    parallel_mode |-> !start_sect;
  endproperty
  a_parallel_no_sect: assert property (p_parallel_no_sect)
    else $error("sector erase in parallel mode");

endmodule // fcs_top

// [tb/fcs_cpu_model.sv]
`timescale 1ns/1ps

// ****************************************************************
// cpu core running its control program from ram
// ****************************************************************
module fcs_cpu_model (
  input  wire logic         clk,
  input  wire logic [7:0]   rd_data,
  input  wire logic         rd_valid,
  output fcs_pkg::fcs_bus_s bus,
  output logic              unlock_wr,
  output logic [3:0]        unlock_wdata,
  output logic              standby_wr,
  output logic              standby_wdata,
  output logic              exec_in_ram,
  output logic              irq_taken,
  output logic              low_power_entry
);
  // idle bus, program starts out in ram with interrupts off
  initial begin
    bus = '{16'h0000, 8'h00, 1'b0, 1'b0};
    {unlock_wr, unlock_wdata, standby_wr, standby_wdata} = 7'h0C;
    {irq_taken, low_power_entry} = 2'h0;
    exec_in_ram = 1'b1;
  end

  // one write strobe, released lines show the inverse
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    bus = '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    #1;
    bus = '{~a, ~d, 1'b0, 1'b0};
  endtask

  // one read strobe, answer taken while rd_valid stands
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk);
    #1;
    bus = '{a, ~bus.wdata, 1'b0, 1'b1};
    @(posedge clk);
    #1;
    v = rd_valid;
    d = rd_data;
    bus = '{~a, ~bus.wdata, 1'b0, 1'b0};
  endtask

  // control strobes: 0 unlock, 1 standby, 2 irq, 3 low power, 4 ram
  task automatic ctl(input logic [2:0] sel, input logic [3:0] v);
    @(posedge clk);
    #1;
    case (sel)
      3'h0: {unlock_wr, unlock_wdata} = {1'b1, v};
      3'h1: {standby_wr, standby_wdata} = {1'b1, v[0]};
      3'h2: irq_taken = 1'b1;
      3'h3: low_power_entry = 1'b1;
      default: exec_in_ram = v[0];
    endcase
    @(posedge clk);
    #1;
    {unlock_wr, standby_wr, irq_taken, low_power_entry} = 4'h0;
  endtask

  // polls one address until two reads agree
  task automatic poll(input logic [15:0] a, input int lim);
    logic [7:0] p;
    logic [7:0] q;
    logic       v;
    int         n;
    rd(a, p, v);
    rd(a, q, v);
    for (n = 0; n < lim && p !== q; n++) begin
      p = q;
      rd(a, q, v);
    end
  endtask
endmodule // fcs_cpu_model

// [tb/testbench.sv]
`timescale 1ns/1ps

module testbench;
  localparam int         ERASE_N = 20000;
  localparam int         PROG_N  = fcs_pkg::PROG_CYC;
  localparam logic [7:0] VEND    = 8'hC3; // arbitrary value
  localparam logic [7:0] MAC     = 8'h96; // arbitrary value
  logic              clk;
  logic              reset_n;
  logic              low_power_mode;
  logic              parallel_mode;
  fcs_pkg::fcs_bus_s bus;
  logic [7:0]        rd_data;
  logic              rd_valid;
  logic              busy;
  logic              id_mode;
  logic [3:0]        field;
  logic              sb_bit;
  logic              cut;
  logic              unlock_wr;
  logic [3:0]        unlock_wdata;
  logic              standby_wr;
  logic              standby_wdata;
  logic              exec_in_ram;
  logic              irq_taken;
  logic              low_power_entry;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  int                t0;

  fcs_top #(.ERASE_CYCLES(ERASE_N), .VENDOR_ID(VEND), .MACRO_ID(MAC)) dut (
    .clk(clk), .reset_n(reset_n), .bus(bus), .unlock_wr(unlock_wr),
    .unlock_wdata(unlock_wdata), .standby_wr(standby_wr),
    .standby_wdata(standby_wdata), .exec_in_ram(exec_in_ram),
    .irq_taken(irq_taken), .low_power_entry(low_power_entry),
    .low_power_mode(low_power_mode), .parallel_mode(parallel_mode),
    .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
    .id_mode(id_mode), .command_unlock_field(field),
    .standby_request_bit(sb_bit), .flash_current_cut(cut));

  fcs_cpu_model cpu (
    .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .bus(bus),
    .unlock_wr(unlock_wr), .unlock_wdata(unlock_wdata),
    .standby_wr(standby_wr), .standby_wdata(standby_wdata),
    .exec_in_ram(exec_in_ram), .irq_taken(irq_taken),
    .low_power_entry(low_power_entry));

  // ****************************************************************
  // helpers
  // ****************************************************************
  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    cpu.rd(a, d, v);
    chk(v, 1'b1);
    chk(d, exp);
  endtask

  // unlock prefix with varied upper address bits
  task automatic cmd(input logic [7:0] d3);
    cpu.wr(16'hC555, 8'hAA);
    cpu.wr(16'hDAAA, 8'h55);
    cpu.wr(16'hE555, d3);
  endtask

  task automatic erase_pre();
    cmd(8'h80);
    cpu.wr(16'hF555, 8'hAA);
    cpu.wr(16'hCAAA, 8'h55);
  endtask

  // final write, then two toggle reads of the erased base byte at once
  task automatic go(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] d1;
    logic [7:0] d2;
    logic       v;
    cpu.wr(a, d);
    t0 = cyc;
    cpu.rd(fcs_pkg::FLASH_BASE, d1, v);
    cpu.rd(fcs_pkg::FLASH_BASE, d2, v);
    chk(busy, 1'b1);
    chk(d1[6], 1'b1);
    chk(d1 ^ d2, 8'h40);
  endtask

  task automatic done(input int lim);
    while (busy !== 1'b0 && cyc - t0 < lim + 10) step(1);
    chk(cyc - t0 <= lim + 6 && cyc - t0 >= lim / 2, 1'b1);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_locked();
    chk(field, 4'hC);
    chk({busy, id_mode, sb_bit, cut, rd_valid}, 8'h00);
    cmd(8'hA0);
    cpu.wr(16'hC010, 8'h00);
    step(3);
    chk(busy, 1'b0);
    cpu.ctl(3'h0, 4'h3);
    chk(field, 4'h3);
    cpu.ctl(3'h0, 4'hC);
    chk(field, 4'hC);
    erase_pre();
    cpu.wr(16'hC555, 8'h10);
    step(3);
    chk(busy, 1'b0);
  endtask

  task automatic t_chip();
    cpu.ctl(3'h0, 4'h3);
    erase_pre();
    go(16'hD555, 8'h10);
    done(ERASE_N);
    rdchk(16'hC000, 8'hFF);
    rdchk(16'hFFFF, 8'hFF);
  endtask

  task automatic t_prog();
    cmd(8'hA0);
    go(16'hC123, 8'h5A);
    cmd(8'hA0);
    cpu.wr(16'hC124, 8'h00);
    done(PROG_N);
    rdchk(16'hC123, 8'h5A);
    rdchk(16'hC124, 8'hFF);
    cpu.wr(16'hC555, 8'hAA);
    cpu.wr(16'hDAAA, 8'h54);
    cpu.wr(16'hE555, 8'hA0);
    cpu.wr(16'hC200, 8'h00);
    step(3);
    chk(busy, 1'b0);
    rdchk(16'hC200, 8'hFF);
  endtask

  task automatic t_sector();
    cmd(8'hA0);
    go(16'hD000, 8'h12);
    done(PROG_N);
    cmd(8'hA0);
    go(16'hE000, 8'h34);
    done(PROG_N);
    parallel_mode = 1'b1;
    erase_pre();
    cpu.wr(16'hD7AB, 8'h30);
    step(3);
    chk(busy, 1'b0);
    parallel_mode = 1'b0;
    erase_pre();
    go(16'hD7AB, 8'h30);
    cpu.poll(16'hD7AB, ERASE_N);
    done(ERASE_N);
    rdchk(16'hD000, 8'hFF);
    rdchk(16'hE000, 8'h34);
  endtask

  task automatic t_id();
    cmd(8'h90);
    step(2);
    chk(id_mode, 1'b1);
    rdchk(16'hF000, VEND);
    rdchk(16'hF001, MAC);
    rdchk(16'hF002, fcs_pkg::ID_SIZE_16K);
    rdchk(16'hFF7F, 8'hFF);
    cpu.wr(16'hC000, 8'hF0);
    step(2);
    chk(id_mode, 1'b0);
    cmd(8'hA5);
    go(fcs_pkg::SEC_ADDR, 8'h00);
    done(PROG_N);
    cmd(8'h90);
    rdchk(16'hFF7F, 8'h00);
    cmd(8'hF0);
    step(2);
    chk(id_mode, 1'b0);
  endtask

  task automatic t_standby();
    logic [7:0] d;
    logic       v;
    cpu.ctl(3'h4, 4'h0);
    cpu.ctl(3'h1, 4'h1);
    chk(cut, 1'b0);
    cpu.ctl(3'h1, 4'h0);
    cpu.ctl(3'h4, 4'h1);
    cpu.ctl(3'h1, 4'h1);
    chk({sb_bit, cut}, 8'h03);
    cpu.rd(16'hC000, d, v);
    step(1);
    chk({sb_bit, cut}, 8'h00);
    cpu.ctl(3'h1, 4'h1);
    cpu.ctl(3'h2, 4'h0);
    chk(sb_bit, 1'b0);
    cpu.ctl(3'h1, 4'h1);
    cpu.ctl(3'h3, 4'h0);
    low_power_mode = 1'b1;
    step(2);
    chk({sb_bit, cut}, 8'h01);
    low_power_mode = 1'b0;
    cpu.ctl(3'h0, 4'hC);
  endtask

  // main sequence
  initial begin
    reset_n = 1'b0;
    low_power_mode = 1'b0;
    parallel_mode = 1'b0;
    step(8);
    reset_n = 1'b1;
    t_locked();
    $display("test locked done");
    t_chip();
    $display("test chip erase done");
    t_prog();
    $display("test program done");
    t_sector();
    $display("test sector erase done");
    t_id();
    $display("test product id done");
    t_standby();
    $display("test standby done");
    end_sim();
  end

  // watchdog
  initial begin
    #(100 * 90000);
    fail_count++;
    end_sim();
  end
endmodule // testbench
